// ===== core/cedfc_params.svh
// constants of the can error detection and fault confinement block
`ifndef CEDFC_PARAMS_SVH
`define CEDFC_PARAMS_SVH

// ==========================================================
// register indices, byte address is four times the index
`define CEDFC_IDX_TX_CNT     8'h1C
`define CEDFC_IDX_RX_CNT     8'h1D
`define CEDFC_IDX_FLAGS      8'h2D
`define CEDFC_IDX_CTRL       8'h30

// ==========================================================
// error_state_flags and ctrl register bit positions
`define CEDFC_EF_RX1_OVR     7
`define CEDFC_EF_RX0_OVR     6
`define CEDFC_EF_BUS_OFF     5
`define CEDFC_EF_TX_PASSIVE  4
`define CEDFC_EF_RX_PASSIVE  3
`define CEDFC_EF_TX_WARN     2
`define CEDFC_EF_RX_WARN     1
`define CEDFC_EF_WARN        0
`define CEDFC_CTRL_HOLD      0

// ==========================================================
// reset values
`define CEDFC_TX_CNT_RST     9'h000
`define CEDFC_RX_CNT_RST     8'h00
`define CEDFC_CTRL_RST       1'b0

// ==========================================================
// fault confinement limits, stuff run limit and check sequence polynomial
`define CEDFC_WARN_LIMIT     9'h060
`define CEDFC_PASSIVE_LIMIT  9'h080
`define CEDFC_BUSOFF_LIMIT   9'h100
`define CEDFC_TX_STEP        9'h008
`define CEDFC_TX_SAT         9'h0F8
`define CEDFC_RX_MAX         8'hFF
`define CEDFC_RX_RESYNC      8'h78
`define CEDFC_STUFF_LIMIT    3'h6
`define CEDFC_RECOV_RUN      11
`define CEDFC_RECOV_COUNT    128
`define CEDFC_CRC_POLY       15'h4599

// ==========================================================
// axi responses
`define CEDFC_RESP_OKAY      2'h0
`define CEDFC_RESP_SLVERR    2'h2

`endif

// ===== core/cedfc_pkg.sv
// types of the can error detection and fault confinement block
package cedfc_pkg;

	// ==========================================================
	// frame field reported by the bit sequencer
	typedef enum logic [3:0] {
		CEDFC_FLD_IDLE      = 4'h0,
		CEDFC_FLD_SOF       = 4'h1,
		CEDFC_FLD_ARB       = 4'h2,
		CEDFC_FLD_CTRL      = 4'h3,
		CEDFC_FLD_DATA      = 4'h4,
		CEDFC_FLD_CRC       = 4'h5,
		CEDFC_FLD_CRC_DELIM = 4'h6,
		CEDFC_FLD_ACK_SLOT  = 4'h7,
		CEDFC_FLD_ACK_DELIM = 4'h8,
		CEDFC_FLD_EOF       = 4'h9,
		CEDFC_FLD_IFS       = 4'hA,
		CEDFC_FLD_ERR_FRAME = 4'hB
	} cedfc_field_t;

	// ==========================================================
	// fault confinement state, gray along active-passive-busoff
	typedef enum logic [1:0] {
		CEDFC_ACTIVE  = 2'h0,
		CEDFC_PASSIVE = 2'h1,
		CEDFC_BUSOFF  = 2'h3
	} cedfc_fault_t;

	// ==========================================================
	// error kind, one flag per kind, several can be set at once
	typedef struct packed {
		logic crc;
		logic ack;
		logic form;
		logic bit_err;
		logic stuff;
	} cedfc_err_kind_t;

	// ==========================================================
	// all state of the top module except the check sequence, which cedfc_crc15 holds
	typedef struct packed {
		cedfc_fault_t    fault;
		logic [8:0]      transmit_error_count;
		logic [7:0]      receive_error_count;
		logic            rx1_ovr;
		logic            rx0_ovr;
		logic            hold;
		logic [2:0]      run;
		logic            last_bit;
		logic [3:0]      recov_run;
		logic [7:0]      recov_cnt;
		logic            err_start;
		logic            err_dom;
		logic            tx_abort;
		cedfc_err_kind_t err_kind;
		logic            aw_got;
		logic            w_got;
		logic [7:0]      aw_idx;
		logic [7:0]      wdata;
		logic            wstrb0;
		logic            awready;
		logic            wready;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arready;
		logic            rvalid;
		logic [1:0]      rresp;
		logic [7:0]      rdata;
	} cedfc_state_t;

	// ==========================================================
	// state of the check sequence generator
	typedef struct packed {
		logic [14:0] crc;
	} cedfc_crc_state_t;

endpackage : cedfc_pkg

// ===== core/cedfc_crc15.sv
// can check sequence generator, fifteen bit polynomial
`timescale 1ns/10ps
`default_nettype none
`include "cedfc_params.svh"

module cedfc_crc15 (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        clear,
	input  wire logic        shift,
	input  wire logic        din,
	output logic [14:0]      crc
);

	cedfc_pkg::cedfc_crc_state_t s_reg;
	cedfc_pkg::cedfc_crc_state_t s_next;
	logic                        fb;

	always_comb begin
		s_next = s_reg;
		fb     = din ^ s_reg.crc[14];
		if (clear) begin
			s_next.crc = 15'h0000;
		end else if (shift) begin
			s_next.crc = {s_reg.crc[13:0], 1'b0} ^ (fb ? `CEDFC_CRC_POLY : 15'h0000);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign crc = s_reg.crc;

endmodule : cedfc_crc15
`default_nettype wire

// ===== core/cedfc_top.sv
// can error detection and fault confinement with axi4-lite registers
`timescale 1ns/10ps
`default_nettype none
`include "cedfc_params.svh"

module cedfc_top #(
	parameter int unsigned ADDR_W      = 12,
	parameter int unsigned RECOV_RUN   = `CEDFC_RECOV_RUN,
	parameter int unsigned RECOV_COUNT = `CEDFC_RECOV_COUNT
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// bit sequencer side
	input  wire logic              bit_strobe,
	input  wire logic              bus_rx_bit,
	input  wire logic              tx_bit,
	input  wire logic              transmitting,
	input  wire logic [3:0]        frame_field,
	input  wire logic              stuff_bit,
	input  wire logic              tx_frame_done,
	input  wire logic              rx_frame_done,
	input  wire logic              rx_store0,
	input  wire logic              rx_store1,
	input  wire logic              rx_buffer0_full_irq_flag,
	input  wire logic              rx_buffer1_full_irq_flag,
	output logic [14:0]            crc_seq,
	output logic                   error_frame_start,
	output logic                   error_flag_dominant,
	output logic                   tx_abort,
	output logic [4:0]             error_kind,
	output logic                   node_enable,
	output logic                   error_passive,
	output logic                   bus_off,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	cedfc_pkg::cedfc_state_t    r_reg;
	cedfc_pkg::cedfc_state_t    r_next;
	cedfc_pkg::cedfc_field_t    fld;
	cedfc_pkg::cedfc_err_kind_t kind;
	logic [14:0]                crc_val;
	logic                       crc_clear;
	logic                       crc_shift;
	logic                       in_stuffed;
	logic                       err_any;
	logic [8:0]                 tec_n;
	logic [7:0]                 rec_n;
	logic [7:0]                 error_state_flags;
	logic [7:0]                 ar_idx;
	logic                       wr_do;

	assign fld = cedfc_pkg::cedfc_field_t'(frame_field);

	// ==========================================================
	// check sequence
	// cleared at frame start; transmitter freezes it through the crc field
	assign crc_clear = bit_strobe && (fld == cedfc_pkg::CEDFC_FLD_SOF);
	assign crc_shift = bit_strobe && !stuff_bit && (r_reg.fault != cedfc_pkg::CEDFC_BUSOFF) &&
		((fld == cedfc_pkg::CEDFC_FLD_ARB) || (fld == cedfc_pkg::CEDFC_FLD_CTRL) ||
		(fld == cedfc_pkg::CEDFC_FLD_DATA) || ((fld == cedfc_pkg::CEDFC_FLD_CRC) && !transmitting));

	cedfc_crc15 u_crc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.clear   (crc_clear),
		.shift   (crc_shift),
		.din     (bus_rx_bit),
		.crc     (crc_val)
	);

	assign in_stuffed = (fld == cedfc_pkg::CEDFC_FLD_SOF) || (fld == cedfc_pkg::CEDFC_FLD_ARB) ||
		(fld == cedfc_pkg::CEDFC_FLD_CTRL) || (fld == cedfc_pkg::CEDFC_FLD_DATA) ||
		(fld == cedfc_pkg::CEDFC_FLD_CRC);

	// ==========================================================
	// error detection
	always_comb begin
		kind       = '0;
		// remainder is zero when the received sequence matches
		kind.crc   = (fld == cedfc_pkg::CEDFC_FLD_CRC_DELIM) && !transmitting && (crc_val != 15'h0000);
		kind.ack   = (fld == cedfc_pkg::CEDFC_FLD_ACK_SLOT) && transmitting && bus_rx_bit;
		kind.form  = !bus_rx_bit && ((fld == cedfc_pkg::CEDFC_FLD_CRC_DELIM) ||
			(fld == cedfc_pkg::CEDFC_FLD_ACK_DELIM) || (fld == cedfc_pkg::CEDFC_FLD_EOF) ||
			(fld == cedfc_pkg::CEDFC_FLD_IFS));
		kind.bit_err = transmitting && (bus_rx_bit != tx_bit) && (fld != cedfc_pkg::CEDFC_FLD_IDLE) &&
			(fld != cedfc_pkg::CEDFC_FLD_ERR_FRAME) &&
			!(tx_bit && !bus_rx_bit && ((fld == cedfc_pkg::CEDFC_FLD_ARB) ||
			(fld == cedfc_pkg::CEDFC_FLD_ACK_SLOT)));
		kind.stuff = in_stuffed && (fld != cedfc_pkg::CEDFC_FLD_SOF) && (bus_rx_bit == r_reg.last_bit) &&
			(r_reg.run == `CEDFC_STUFF_LIMIT - 3'h1);
		if (!bit_strobe || (r_reg.fault == cedfc_pkg::CEDFC_BUSOFF)) begin
			kind = '0;
		end
	end

	assign err_any = |kind;

	// ==========================================================
	// error counters
	always_comb begin
		tec_n = r_reg.transmit_error_count;
		rec_n = r_reg.receive_error_count;
		if (r_reg.fault != cedfc_pkg::CEDFC_BUSOFF) begin
			if (err_any && transmitting) begin
				tec_n = (r_reg.transmit_error_count >= `CEDFC_TX_SAT) ? `CEDFC_BUSOFF_LIMIT : r_reg.transmit_error_count + `CEDFC_TX_STEP;
			end else if (err_any) begin
				rec_n = (r_reg.receive_error_count == `CEDFC_RX_MAX) ? r_reg.receive_error_count : r_reg.receive_error_count + 8'h01;
			end else if (tx_frame_done && (r_reg.transmit_error_count != 9'h000)) begin
				tec_n = r_reg.transmit_error_count - 9'h001;
			end else if (rx_frame_done) begin
				if (r_reg.receive_error_count >= `CEDFC_PASSIVE_LIMIT) begin
					rec_n = `CEDFC_RX_RESYNC;
				end else if (r_reg.receive_error_count != 8'h00) begin
					rec_n = r_reg.receive_error_count - 8'h01;
				end
			end
		end
	end

	// ==========================================================
	// error flag register view
	always_comb begin
		error_state_flags                        = 8'h00;
		error_state_flags[`CEDFC_EF_RX1_OVR]     = r_reg.rx1_ovr;
		error_state_flags[`CEDFC_EF_RX0_OVR]     = r_reg.rx0_ovr;
		error_state_flags[`CEDFC_EF_BUS_OFF]     = (r_reg.fault == cedfc_pkg::CEDFC_BUSOFF);
		error_state_flags[`CEDFC_EF_TX_PASSIVE]  = (r_reg.transmit_error_count >= `CEDFC_PASSIVE_LIMIT);
		error_state_flags[`CEDFC_EF_RX_PASSIVE]  = ({1'b0, r_reg.receive_error_count} >= `CEDFC_PASSIVE_LIMIT);
		error_state_flags[`CEDFC_EF_TX_WARN]     = (r_reg.transmit_error_count >= `CEDFC_WARN_LIMIT);
		error_state_flags[`CEDFC_EF_RX_WARN]     = ({1'b0, r_reg.receive_error_count} >= `CEDFC_WARN_LIMIT);
		error_state_flags[`CEDFC_EF_WARN]        = error_state_flags[`CEDFC_EF_TX_WARN] || error_state_flags[`CEDFC_EF_RX_WARN];
	end

	assign ar_idx = s_axi_araddr[9:2];
	assign wr_do  = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;

	// ==========================================================
	// next state
	always_comb begin
		r_next           = r_reg;
		r_next.err_start = 1'b0;
		r_next.tx_abort  = 1'b0;
		r_next.err_kind  = '0;
		r_next.transmit_error_count       = tec_n;
		r_next.receive_error_count       = rec_n;

		// stuff run length over raw bus bits
		if (bit_strobe) begin
			r_next.last_bit = bus_rx_bit;
			if (!in_stuffed || (fld == cedfc_pkg::CEDFC_FLD_SOF) || (bus_rx_bit != r_reg.last_bit)) begin
				r_next.run = 3'h1;
			end else if (r_reg.run != `CEDFC_STUFF_LIMIT) begin
				r_next.run = r_reg.run + 3'h1;
			end
		end

		// error frame request, flag type taken from state at the error
		if (err_any) begin
			r_next.err_start = 1'b1;
			r_next.err_kind  = kind;
			r_next.tx_abort  = transmitting;
			r_next.err_dom   = (r_reg.fault == cedfc_pkg::CEDFC_ACTIVE);
		end

		// fault confinement
		unique case (r_reg.fault)
			cedfc_pkg::CEDFC_ACTIVE, cedfc_pkg::CEDFC_PASSIVE: begin
				r_next.recov_run = 4'h0;
				r_next.recov_cnt = 8'h00;
				if (tec_n >= `CEDFC_BUSOFF_LIMIT) begin
					r_next.fault = cedfc_pkg::CEDFC_BUSOFF;
				end else if ((tec_n >= `CEDFC_PASSIVE_LIMIT) || ({1'b0, rec_n} >= `CEDFC_PASSIVE_LIMIT)) begin
					r_next.fault = cedfc_pkg::CEDFC_PASSIVE;
				end else begin
					r_next.fault = cedfc_pkg::CEDFC_ACTIVE;
				end
			end
			cedfc_pkg::CEDFC_BUSOFF: begin
				if (bit_strobe) begin
					if (!bus_rx_bit) begin
						r_next.recov_run = 4'h0;
					end else if (r_reg.recov_run == 4'(RECOV_RUN - 1)) begin
						r_next.recov_run = 4'h0;
						if (r_reg.recov_cnt != 8'(RECOV_COUNT)) begin
							r_next.recov_cnt = r_reg.recov_cnt + 8'h01;
						end
					end else begin
						r_next.recov_run = r_reg.recov_run + 4'h1;
					end
				end
				if ((r_reg.recov_cnt == 8'(RECOV_COUNT)) && !r_reg.hold) begin
					r_next.fault = cedfc_pkg::CEDFC_ACTIVE;
					r_next.transmit_error_count   = `CEDFC_TX_CNT_RST;
					r_next.receive_error_count   = `CEDFC_RX_CNT_RST;
				end
			end
			default: begin
				r_next.fault = cedfc_pkg::CEDFC_BUSOFF;
			end
		endcase

		// write channels taken in either order
		if (s_axi_awvalid && r_reg.awready) begin
			r_next.aw_got = 1'b1;
			r_next.aw_idx = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && r_reg.wready) begin
			r_next.w_got  = 1'b1;
			r_next.wdata  = s_axi_wdata[7:0];
			r_next.wstrb0 = s_axi_wstrb[0];
		end
		if (wr_do) begin
			r_next.aw_got = 1'b0;
			r_next.w_got  = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp  = `CEDFC_RESP_OKAY;
			if (r_reg.aw_idx == `CEDFC_IDX_FLAGS) begin
				if (r_reg.wstrb0) begin
					// writing zero clears an overflow flag, writing one keeps it
					r_next.rx1_ovr = r_reg.rx1_ovr && r_reg.wdata[`CEDFC_EF_RX1_OVR];
					r_next.rx0_ovr = r_reg.rx0_ovr && r_reg.wdata[`CEDFC_EF_RX0_OVR];
				end
			end else if (r_reg.aw_idx == `CEDFC_IDX_CTRL) begin
				if (r_reg.wstrb0) begin
					r_next.hold = r_reg.wdata[`CEDFC_CTRL_HOLD];
				end
			end else if ((r_reg.aw_idx != `CEDFC_IDX_TX_CNT) && (r_reg.aw_idx != `CEDFC_IDX_RX_CNT)) begin
				r_next.bresp = `CEDFC_RESP_SLVERR;
			end
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		r_next.awready = !r_next.aw_got && !r_next.bvalid;
		r_next.wready  = !r_next.w_got && !r_next.bvalid;

		// overflow set after the host write so that set wins
		if (rx_store1 && rx_buffer1_full_irq_flag && (r_reg.fault != cedfc_pkg::CEDFC_BUSOFF)) begin
			r_next.rx1_ovr = 1'b1;
		end
		if (rx_store0 && rx_buffer0_full_irq_flag && (r_reg.fault != cedfc_pkg::CEDFC_BUSOFF)) begin
			r_next.rx0_ovr = 1'b1;
		end

		// read channel
		if (s_axi_arvalid && r_reg.arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = `CEDFC_RESP_OKAY;
			unique case (ar_idx)
				`CEDFC_IDX_TX_CNT: r_next.rdata = r_reg.transmit_error_count[7:0];
				`CEDFC_IDX_RX_CNT: r_next.rdata = r_reg.receive_error_count;
				`CEDFC_IDX_FLAGS:  r_next.rdata = error_state_flags;
				`CEDFC_IDX_CTRL: r_next.rdata = {7'h00, r_reg.hold};
				default: begin
					r_next.rdata = 8'h00;
					r_next.rresp = `CEDFC_RESP_SLVERR;
				end
			endcase
		end else if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		r_next.arready = !r_next.rvalid;
	end

	// ==========================================================
	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg       <= '0;
			r_reg.fault <= cedfc_pkg::CEDFC_ACTIVE;
			r_reg.transmit_error_count   <= `CEDFC_TX_CNT_RST;
			r_reg.receive_error_count   <= `CEDFC_RX_CNT_RST;
			r_reg.hold  <= `CEDFC_CTRL_RST;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// outputs
	assign crc_seq             = crc_val;
	assign error_frame_start   = r_reg.err_start;
	assign error_flag_dominant = r_reg.err_dom;
	assign tx_abort            = r_reg.tx_abort;
	assign error_kind          = r_reg.err_kind;
	assign node_enable         = (r_reg.fault != cedfc_pkg::CEDFC_BUSOFF);
	assign error_passive       = (r_reg.fault == cedfc_pkg::CEDFC_PASSIVE);
	assign bus_off             = r_reg.fault[1];
	assign s_axi_awready       = r_reg.awready;
	assign s_axi_wready        = r_reg.wready;
	assign s_axi_bvalid        = r_reg.bvalid;
	assign s_axi_bresp         = r_reg.bresp;
	assign s_axi_arready       = r_reg.arready;
	assign s_axi_rvalid        = r_reg.rvalid;
	assign s_axi_rresp         = r_reg.rresp;
	assign s_axi_rdata         = {24'h000000, r_reg.rdata};

endmodule : cedfc_top
`default_nettype wire

// ===== sim/cedfc_properties.sv
// port assertions of the error detection and fault confinement block
`timescale 1ns/10ps
`default_nettype none
module cedfc_checker (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       ce,
	input wire logic       bit_strobe,
	input wire logic       bus_rx_bit,
	input wire logic       tx_bit,
	input wire logic       transmitting,
	input wire logic [3:0] frame_field,
	input wire logic       error_frame_start,
	input wire logic       error_flag_dominant,
	input wire logic       tx_abort,
	input wire logic [4:0] error_kind,
	input wire logic       node_enable,
	input wire logic       error_passive,
	input wire logic       bus_off
);
	wire logic stb;
	assign stb = bit_strobe && ce;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// sequences
	sequence no_ack_s;
		stb && transmitting && node_enable && frame_field == 4'h7 && bus_rx_bit;
	endsequence
	sequence rx_data_s(logic lvl);
		stb && !transmitting && node_enable && frame_field == 4'h4 && bus_rx_bit == lvl;
	endsequence
	// ==========================================================
	// assertions
	ack_error_a: assert property (no_ack_s |=> error_frame_start && tx_abort && error_kind == 5'h08)
		else $error("missing ack error");
	form_error_a: assert property (stb && !transmitting && node_enable && !bus_rx_bit && frame_field inside {4'h6, 4'h8, 4'h9, 4'hA} |=> error_frame_start)
		else $error("missing form error");
	bit_error_a: assert property (stb && transmitting && node_enable && frame_field inside {4'h3, 4'h4} && tx_bit != bus_rx_bit |=> error_frame_start && tx_abort && error_kind[1])
		else $error("missing bit error");
	arb_quiet_a: assert property (stb && transmitting && frame_field == 4'h2 && tx_bit && !bus_rx_bit |=> !error_kind[1])
		else $error("bit error in arbitration");
	stuff_error_a: assert property (rx_data_s(1'b1) ##1 rx_data_s(1'b0) [*6] |=> error_frame_start && error_kind[0])
		else $error("missing stuff error");
	flag_level_a: assert property (error_frame_start |-> error_flag_dominant == !$past(error_passive))
		else $error("error flag level wrong");
	busoff_quiet_a: assert property (bus_off && stb |=> !error_frame_start)
		else $error("error frame in bus-off");
	busoff_node_a: assert property (bus_off |-> !node_enable)
		else $error("node enabled in bus-off");
	busoff_hold_a: assert property (bus_off && !(stb && bus_rx_bit) && !$past(stb && bus_rx_bit) |=> bus_off)
		else $error("bus-off left early");
endmodule : cedfc_checker
bind cedfc_top cedfc_checker u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce), .bit_strobe(bit_strobe),
	.bus_rx_bit(bus_rx_bit), .tx_bit(tx_bit), .transmitting(transmitting), .frame_field(frame_field),
	.error_frame_start(error_frame_start), .error_flag_dominant(error_flag_dominant), .tx_abort(tx_abort),
	.error_kind(error_kind), .node_enable(node_enable), .error_passive(error_passive), .bus_off(bus_off));
`default_nettype wire

// ===== sim/cedfc_bus_nodes.sv
// other nodes on the shared bus, wired-and with recessive idle
`timescale 1ns/10ps
`default_nettype none
module cedfc_bus_nodes (
	input wire logic       transmitting,
	input wire logic       tx_bit,
	input wire logic [3:0] frame_field,
	input wire logic       peer_bit,
	input wire logic       ack_en,
	output logic           bus_rx_bit
);
	// peers pull low; acknowledge only when asked to
	assign bus_rx_bit = (tx_bit | !transmitting) & peer_bit & !(ack_en && transmitting && frame_field == 4'h7);
endmodule : cedfc_bus_nodes
`default_nettype wire

// ===== sim/cedfc_tb.sv
// self-checking testbench of the error detection block
`timescale 1ns/10ps
`default_nettype none
`include "cedfc_params.svh"
module tb;
	typedef struct {int ne; int nk; logic [7:0] txc; logic [7:0] ef;} cedfc_row_t;
	logic        aclk, aresetn, ce, bit_strobe, bus_rx_bit, tx_bit, transmitting, txd, rxd, st0, st1, irq0, irq1;
	logic        peer, ack_en, efs, efd, abt, ne, ep, bo;
	logic [3:0]  fld, wstrb;
	logic [4:0]  ek;
	logic [14:0] crc_seq;
	logic [11:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	int          failures, n_checks;
	cedfc_row_t  rows [6];
	localparam logic [11:0] A_TXC = {2'b00, `CEDFC_IDX_TX_CNT, 2'b00};
	localparam logic [11:0] A_RXC = {2'b00, `CEDFC_IDX_RX_CNT, 2'b00};
	localparam logic [11:0] A_EF = {2'b00, `CEDFC_IDX_FLAGS, 2'b00};
	always #10 aclk = ~aclk;
	cedfc_bus_nodes u_bus (.transmitting(transmitting), .tx_bit(tx_bit), .frame_field(fld), .peer_bit(peer),
		.ack_en(ack_en), .bus_rx_bit(bus_rx_bit));
	cedfc_top #(.RECOV_RUN(3), .RECOV_COUNT(2)) u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.bit_strobe(bit_strobe), .bus_rx_bit(bus_rx_bit), .tx_bit(tx_bit), .transmitting(transmitting),
		.frame_field(fld), .stuff_bit(1'b0), .tx_frame_done(txd), .rx_frame_done(rxd), .rx_store0(st0),
		.rx_store1(st1), .rx_buffer0_full_irq_flag(irq0), .rx_buffer1_full_irq_flag(irq1), .crc_seq(crc_seq),
		.error_frame_start(efs), .error_flag_dominant(efd), .tx_abort(abt), .error_kind(ek), .node_enable(ne),
		.error_passive(ep), .bus_off(bo), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// ==========================================================
	// tasks
	task automatic complete_run();
		if (failures == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		int   i;
		logic ab, wb, bb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		i = 0;
		bb = 1'b0;
		while (!bb && i < 200) begin
			#1;
			ab = (awvalid && awready) === 1'b1;
			wb = (wvalid && wready) === 1'b1;
			bb = (bvalid === 1'b1);
			@(posedge aclk);
			i++;
			if (ab) awvalid <= 1'b0;
			if (wb) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!bb) begin
			failures++;
			complete_run();
		end
	endtask : wr
	task automatic rd(input logic [11:0] a);
		int   i;
		logic ab, rb;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		i = 0;
		rb = 1'b0;
		while (!rb && i < 200) begin
			#1;
			ab = (arvalid && arready) === 1'b1;
			rb = (rvalid === 1'b1);
			d = rdata;
			r = rresp;
			@(posedge aclk);
			i++;
			if (ab) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!rb) begin
			failures++;
			complete_run();
		end
	endtask : rd
	task automatic sb(input logic [3:0] f, input logic tx, input logic b, input logic p);
		@(posedge aclk);
		fld <= f;
		transmitting <= tx;
		tx_bit <= b;
		peer <= p;
		bit_strobe <= 1'b1;
	endtask : sb
	task automatic stop();
		@(posedge aclk);
		bit_strobe <= 1'b0;
		#1;
	endtask : stop
	function automatic logic [14:0] crc_f(input logic [15:0] b);
		logic [14:0] x;
		x = 15'h0000;
		for (int i = 15; i >= 0; i--) x = {x[13:0], 1'b0} ^ ((b[i] ^ x[14]) ? `CEDFC_CRC_POLY : 15'h0000);
		return x;
	endfunction : crc_f
	// ==========================================================
	// main sequence
	initial begin
		{aclk, aresetn, bit_strobe, transmitting, txd, rxd, st0, st1, irq0, irq1, ack_en} = '0;
		{awvalid, wvalid, bready, arvalid, rready, tx_bit, peer, wstrb, fld} = {7'h00, 2'b11, 4'hF, 4'h0};
		{awaddr, araddr, wdata, failures, n_checks} = '0;
		ce = 1'b1;
		rows[0] = '{11, 0, 8'h58, 8'h00};
		rows[1] = '{1, 0, 8'h60, 8'h05};
		rows[2] = '{0, 1, 8'h5F, 8'h00};
		rows[3] = '{4, 0, 8'h7F, 8'h05};
		rows[4] = '{1, 0, 8'h87, 8'h15};
		rows[5] = '{0, 8, 8'h7F, 8'h05};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(A_EF);
		chk(d, 32'h0);
		foreach (rows[i]) begin
			repeat (rows[i].ne) begin
				sb(4'h7, 1'b1, 1'b1, 1'b1);
				stop();
			end
			repeat (rows[i].nk) begin
				@(posedge aclk) txd <= 1'b1;
				@(posedge aclk) txd <= 1'b0;
			end
			rd(A_TXC);
			chk(d, {24'h0, rows[i].txc});
			rd(A_EF);
			chk(d, {24'h0, rows[i].ef});
			chk(ep, rows[i].ef[4]);
		end
		ce <= 1'b0;
		sb(4'h7, 1'b1, 1'b1, 1'b1);
		stop();
		chk(efs, 1'b0);
		ce <= 1'b1;
		wr(A_RXC, 8'hFF);
		sb(4'h9, 1'b0, 1'b1, 1'b0);
		stop();
		chk({efs, ek, efd}, 7'h49);
		sb(4'h4, 1'b0, 1'b1, 1'b1);
		repeat (6) sb(4'h4, 1'b0, 1'b1, 1'b0);
		stop();
		chk(ek, 5'h01);
		@(posedge aclk) rxd <= 1'b1;
		@(posedge aclk) rxd <= 1'b0;
		rd(A_RXC);
		chk(d, 32'h1);
		sb(4'h4, 1'b1, 1'b1, 1'b0);
		stop();
		chk({ek, abt}, 6'h05);
		sb(4'h2, 1'b1, 1'b1, 1'b0);
		ack_en <= 1'b1;
		sb(4'h7, 1'b1, 1'b1, 1'b1);
		stop();
		chk(efs, 1'b0);
		ack_en <= 1'b0;
		rd(12'h000);
		chk(d, 32'h0);
		chk(r, `CEDFC_RESP_SLVERR);
		@(posedge aclk) {irq0, st0, st1} <= 3'h7;
		@(posedge aclk) {irq0, st0, st1} <= 3'h0;
		rd(A_EF);
		chk(d, 32'h55);
		wr(A_EF, 8'h00);
		rd(A_EF);
		chk(d, 32'h15);
		sb(4'h0, 1'b0, 1'b1, 1'b1);
		for (int i = 15; i >= 0; i--) sb((i == 15) ? 4'h1 : 4'h4, 1'b1, 16'h5A6C >> i, 1'b1);
		stop();
		chk(crc_seq, crc_f(16'h5A6C));
		repeat (16) begin
			sb(4'h7, 1'b1, 1'b1, 1'b1);
			stop();
		end
		chk({efd, bo, ne}, 3'h2);
		sb(4'h7, 1'b1, 1'b1, 1'b1);
		sb(4'h0, 1'b0, 1'b1, 1'b0);
		repeat (5) sb(4'h0, 1'b0, 1'b1, 1'b1);
		stop();
		chk({efs, bo}, 2'h1);
		sb(4'h0, 1'b0, 1'b1, 1'b1);
		stop();
		@(posedge aclk);
		#1;
		chk({bo, ne}, 2'h1);
		rd(A_TXC);
		chk(d, 32'h0);
		complete_run();
	end
endmodule : tb
`default_nettype wire
